// ===== rtl/lsb_exec_unit.sv
// execution unit for data transfer, stack, i/o bit, shift and flag instructions
//
// What this block does
// - post-increment indirect load: read at pointer, then pointer plus one; 2 cycles
// - pre-decrement indirect load: pointer minus one, then read; 2 cycles, no flags
// - offset load: read at Y or Z plus offset, pointer kept; 2 cycles
// - absolute load copies the byte at the given address; 2 cycles, no flags
// - post-increment indirect store: write at pointer, then increment; 2 cycles
// - pre-decrement indirect store: decrement pointer, then write; 2 cycles
// - offset store writes at Y or Z plus offset, pointer kept; 2 cycles
// - absolute store writes the source to the given address; 2 cycles
// - push puts the source register on the stack in 2 cycles
// - pop takes the top stack byte into the destination; 2 cycles
// - io bit force one sets one bit of an io register; 2 cycles
// - io bit force zero clears one bit of an io register; 2 cycles
// - rotate left via carry; updates Z, C, N, V in 1 cycle
// - rotate right via carry; updates Z, C, N, V in 1 cycle
// - arithmetic shift right keeps the top bit; Z, C, N, V; 1 cycle
// - bit to transfer flag copies a register bit into T; 1 cycle
// - transfer flag to bit writes T into a register bit; 1 cycle
// - global irq on sets I only, 1 cycle
// - global irq off clears I only, 1 cycle
// - overflow flag on and off, each 1 cycle, only V
// - half carry on and off, each 1 cycle, only H
// - sign test on and off, each 1 cycle, only S
// - extended prog fetch reads page:Z into r0 in 3 cycles
`timescale 1ns/100ps
module lsb_exec_unit (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // data memory and stack
    output lsb_pkg::lsb_dm_req_t dm_req,
    input wire logic [7:0] dm_rdata,
    // io register space
    output lsb_pkg::lsb_io_req_t io_req,
    // program memory
    output lsb_pkg::lsb_pm_req_t pm_req,
    input wire logic [7:0] pm_rdata
);
    import lsb_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_C1, S_C2, S_C3} lsb_state_t;

    lsb_state_t st_q;
    lsb_cmd_t cmd_q;
    logic [7:0] rf [0:31];
    logic [7:0] status_flags_reg_q;
    logic [7:0] prog_page_select_q;
    logic [15:0] sp_q;
    logic [15:0] abs_q;
    logic [4:0] gsel_q;
    logic ph_we_q;
    logic [7:0] ph_off_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    lsb_dm_req_t dm_q;
    lsb_io_req_t io_q;
    lsb_pm_req_t pm_q;

    logic addr_ok;
    logic idle;
    logic cmd_go;
    logic ptr_op;
    logic [4:0] plo;
    logic [15:0] ptr_val;
    logic [15:0] z_val;
    logic [15:0] ptr_nx;
    logic [15:0] ea;
    logic [7:0] rd_val;
    logic [7:0] alu_res;
    logic [7:0] alu_flags;
    logic [1:0] ncyc;

    // ==========================================================
    // ahb-lite slave: zero wait states, always okay
    assign addr_ok = hsel && htrans[1] && hready;
    assign idle = (st_q == S_IDLE);
    // a command written while busy is dropped, never queued
    assign cmd_go = ph_we_q && (ph_off_q == OFF_CMD) && idle;

    // address phase capture for the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_we_q <= 1'b0;
            ph_off_q <= 8'h00;
        end else begin
            ph_we_q <= addr_ok && hwrite;
            ph_off_q <= haddr[7:0];
        end
    end

    // read data is registered in the address phase so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                OFF_CMD: hrdata_q <= {{(32-CMD_W){1'b0}}, cmd_q};
                OFF_ADDR: hrdata_q <= {16'h0000, abs_q};
                OFF_STAT: hrdata_q <= {23'h000000, !idle, status_flags_reg_q};
                OFF_GSEL: hrdata_q <= {27'h0000000, gsel_q};
                OFF_GDATA: hrdata_q <= {24'h000000, rf[gsel_q]};
                OFF_PAGE: hrdata_q <= {24'h000000, prog_page_select_q};
                OFF_SP: hrdata_q <= {16'h0000, sp_q};
                default: hrdata_q <= 32'h0000_0000;
            endcase
        end else begin
            hrdata_q <= 32'h0000_0000;
        end
    end

    // handshake outputs from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    // software-written setup registers; held while busy so a command sees stable inputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            abs_q <= 16'h0000;
            gsel_q <= 5'h00;
            prog_page_select_q <= PAGE_RST;
        end else if (ph_we_q && idle) begin
            case (ph_off_q)
                OFF_ADDR: abs_q <= hwdata[15:0];
                OFF_GSEL: gsel_q <= hwdata[4:0];
                OFF_PAGE: prog_page_select_q <= hwdata[7:0];
                default: abs_q <= abs_q;
            endcase
        end
    end

    // ==========================================================
    // command register and sequencing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_q <= '0;
        end else if (cmd_go) begin
            cmd_q <= lsb_cmd_t'(hwdata[CMD_W-1:0]);
        end
    end

    assign ncyc = lsb_ncyc(cmd_q.op);

    // one state per instruction cycle; length set by the operation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= S_IDLE;
        end else begin
            case (st_q)
                S_IDLE: if (cmd_go) st_q <= S_C1;
                S_C1: st_q <= (ncyc > CYC_ALU) ? S_C2 : S_IDLE;
                S_C2: st_q <= (ncyc > CYC_MEM) ? S_C3 : S_IDLE;
                S_C3: st_q <= S_IDLE;
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // pointer pairs and effective address
    // X with an offset has no hardware form; it falls back to plain X
    always_comb begin
        case (cmd_q.psel)
            PS_X: plo = PTR_X_LO;
            PS_Y: plo = PTR_Y_LO;
            default: plo = PTR_Z_LO;
        endcase
    end

    assign ptr_val = {rf[plo + 5'h01], rf[plo]};
    assign z_val = {rf[PTR_Z_LO + 5'h01], rf[PTR_Z_LO]};
    assign rd_val = rf[cmd_q.rsel];
    assign ptr_op = (cmd_q.op == OP_INDIRECT_LOAD) || (cmd_q.op == OP_INDIRECT_STORE);

    // post-increment uses the old value, pre-decrement the new one
    always_comb begin
        ptr_nx = ptr_val;
        ea = ptr_val;
        case (cmd_q.pmode)
            PM_POST_INC: ptr_nx = ptr_val + 16'h0001;
            PM_PRE_DEC: begin
                ptr_nx = ptr_val - 16'h0001;
                ea = ptr_nx;
            end
            PM_OFFSET: if (cmd_q.psel != PS_X) ea = ptr_val + {10'h000, cmd_q.disp};
            default: ea = ptr_val;
        endcase
    end

    lsb_bit_alu u_alu (
        .op(cmd_q.op),
        .bitn(cmd_q.bitn),
        .val(rd_val),
        .flags(status_flags_reg_q),
        .res(alu_res),
        .flags_n(alu_flags)
    );

    // ==========================================================
    // working registers: bus access when idle, results while busy
    // when the destination is half of the pointer, the loaded byte wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 32; i++) begin
                rf[i] <= 8'h00;
            end
        end else begin
            case (st_q)
                S_IDLE: if (ph_we_q && ph_off_q == OFF_GDATA) rf[gsel_q] <= hwdata[7:0];
                S_C1: begin
                    if (ptr_op && (cmd_q.pmode == PM_POST_INC || cmd_q.pmode == PM_PRE_DEC)) begin
                        rf[plo] <= ptr_nx[7:0];
                        rf[plo + 5'h01] <= ptr_nx[15:8];
                    end
                    if (ncyc == CYC_ALU) rf[cmd_q.rsel] <= alu_res;
                end
                S_C2: begin
                    case (cmd_q.op)
                        OP_INDIRECT_LOAD, OP_ABSOLUTE_LOAD, OP_POP:
                            rf[cmd_q.rsel] <= dm_rdata;
                        default: rf[cmd_q.rsel] <= rf[cmd_q.rsel];
                    endcase
                end
                S_C3: if (cmd_q.op == OP_EXTENDED_PROG_FETCH) rf[0] <= pm_rdata;
                default: rf[0] <= rf[0];
            endcase
        end
    end

    // status flags change only on single-cycle datapath operations
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_flags_reg_q <= STATUS_FLAGS_REG_RST;
        end else if (st_q == S_C1 && ncyc == CYC_ALU) begin
            status_flags_reg_q <= alu_flags;
        end
    end

    // stack pointer: post-decrement on push, pre-increment on pop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_q <= SP_RST;
        end else if (idle && ph_we_q && ph_off_q == OFF_SP) begin
            sp_q <= hwdata[15:0];
        end else if (st_q == S_C1 && cmd_q.op == OP_PUSH) begin
            sp_q <= sp_q - 16'h0001;
        end else if (st_q == S_C1 && cmd_q.op == OP_POP) begin
            sp_q <= sp_q + 16'h0001;
        end
    end

    // ==========================================================
    // data memory request stands for the second cycle only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dm_q <= '0;
        end else begin
            dm_q <= '0;
            if (st_q == S_C1) begin
                case (cmd_q.op)
                    OP_INDIRECT_LOAD: dm_q <= '{addr: ea, wdata: 8'h00, we: 1'b0, re: 1'b1};
                    OP_INDIRECT_STORE: dm_q <= '{addr: ea, wdata: rd_val, we: 1'b1, re: 1'b0};
                    OP_ABSOLUTE_LOAD: dm_q <= '{addr: abs_q, wdata: 8'h00, we: 1'b0, re: 1'b1};
                    OP_ABSOLUTE_STORE: dm_q <= '{addr: abs_q, wdata: rd_val, we: 1'b1, re: 1'b0};
                    OP_PUSH: dm_q <= '{addr: sp_q, wdata: rd_val, we: 1'b1, re: 1'b0};
                    OP_POP: dm_q <= '{addr: sp_q + 16'h0001, wdata: 8'h00, we: 1'b0, re: 1'b1};
                    default: dm_q <= '0;
                endcase
            end
        end
    end

    // io bit request; the io space does its own read-modify-write of one bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_q <= '0;
        end else begin
            io_q <= '0;
            if (st_q == S_C1) begin
                io_q.addr <= abs_q[5:0];
                io_q.bitn <= cmd_q.bitn;
                io_q.set <= (cmd_q.op == OP_IO_BIT_FORCE_ONE);
                io_q.clr <= (cmd_q.op == OP_IO_BIT_FORCE_ZERO);
            end
        end
    end

    // program memory request stands for the second and third cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pm_q <= '0;
        end else if (st_q == S_C1 && cmd_q.op == OP_EXTENDED_PROG_FETCH) begin
            pm_q <= '{addr: {prog_page_select_q, z_val}, re: 1'b1};
        end else if (st_q == S_C3 || idle) begin
            pm_q <= '0;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign dm_req = dm_q;
    assign io_req = io_q;
    assign pm_req = pm_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic c1;
    logic c_flag;
    logic rd_msb;
    logic sel_bit;
    logic [7:0] keep_mask;
    assign c1 = (st_q == S_C1);
    assign c_flag = status_flags_reg_q[FLG_C];
    assign rd_msb = rd_val[7];
    assign sel_bit = rd_val[cmd_q.bitn];
    assign keep_mask = ~(8'h01 << cmd_q.bitn);

    AST_POST_INC: assert property (c1 && ptr_op && cmd_q.pmode == PM_POST_INC
        |=> ptr_val == $past(ptr_val) + 16'h0001 && dm_q.addr == $past(ptr_val))
        else $error("post-increment pointer or address wrong");
    AST_PRE_DEC: assert property (c1 && ptr_op && cmd_q.pmode == PM_PRE_DEC
        |=> ptr_val == $past(ptr_val) - 16'h0001 && dm_q.addr == ptr_val)
        else $error("pre-decrement pointer or address wrong");
    AST_OFFSET: assert property (c1 && ptr_op && cmd_q.pmode == PM_OFFSET && cmd_q.psel != PS_X
        |=> $stable(ptr_val) && dm_q.addr == ptr_val + {10'h000, cmd_q.disp})
        else $error("offset address wrong or pointer moved");
    AST_ABS: assert property (c1 && cmd_q.op == OP_ABSOLUTE_LOAD
        |=> dm_q.re && dm_q.addr == abs_q ##1 rd_val == $past(dm_rdata))
        else $error("absolute load address or data wrong");
    AST_TWO_CYC: assert property (c1 && ncyc == CYC_MEM
        |=> st_q == S_C2 && $stable(status_flags_reg_q) ##1 idle && $stable(status_flags_reg_q))
        else $error("memory instruction length or flags wrong");
    AST_PUSH: assert property (c1 && cmd_q.op == OP_PUSH
        |=> dm_q.we && dm_q.wdata == $past(rd_val) && sp_q == dm_q.addr - 16'h0001)
        else $error("push wrong");
    AST_IO_ONE: assert property (c1 && cmd_q.op == OP_IO_BIT_FORCE_ONE
        |=> io_q.set && !io_q.clr && io_q.bitn == cmd_q.bitn ##1 !io_q.set)
        else $error("io bit set request wrong");
    AST_ROL: assert property (c1 && cmd_q.op == OP_ROTATE_LEFT_VIA_CARRY
        |=> idle && c_flag == $past(rd_msb) && rd_val[0] == $past(c_flag))
        else $error("rotate left via carry wrong");
    AST_BST: assert property (c1 && cmd_q.op == OP_BIT_TO_TRANSFER_FLAG
        |=> status_flags_reg_q[FLG_T] == $past(sel_bit))
        else $error("transfer flag not taken from bit");
    AST_FLAG_ON: assert property (c1 && cmd_q.op == OP_FLAG_ON
        |=> status_flags_reg_q[cmd_q.bitn]
            && (status_flags_reg_q & keep_mask) == ($past(status_flags_reg_q) & keep_mask))
        else $error("flag set touched other flags");
    AST_XFETCH: assert property (c1 && cmd_q.op == OP_EXTENDED_PROG_FETCH
        |=> pm_q.re ##1 st_q == S_C3 ##1 idle && rf[0] == $past(pm_rdata))
        else $error("extended fetch timing or data wrong");

    COV_LOAD: cover property (c1 && ptr_op && cmd_q.pmode == PM_POST_INC ##2 idle);
    COV_POP: cover property (c1 && cmd_q.op == OP_POP ##2 idle);
    COV_XFETCH: cover property (c1 && cmd_q.op == OP_EXTENDED_PROG_FETCH ##3 idle);
    COV_BUSY_DROP: cover property (ph_we_q && ph_off_q == OFF_CMD && !idle);

endmodule

// ===== pkg/lsb_pkg.sv
// constants, command encodings and carrier types for the load/store/bit execution unit
package lsb_pkg;

    // ==========================================================
    // register map (byte offsets on the ahb-lite slave)
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_GSEL = 8'h0c;
    localparam logic [7:0] OFF_GDATA = 8'h10;
    localparam logic [7:0] OFF_PAGE = 8'h14;
    localparam logic [7:0] OFF_SP = 8'h18;
    localparam int CMD_W = 23;
    localparam int STAT_BUSY_BIT = 8;

    // ==========================================================
    // pointer pairs live in the working registers, low byte first
    localparam logic [4:0] PTR_X_LO = 5'h1a;
    localparam logic [4:0] PTR_Y_LO = 5'h1c;
    localparam logic [4:0] PTR_Z_LO = 5'h1e;

    // ==========================================================
    // status flag positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam int FLG_T = 6;
    localparam int FLG_I = 7;

    // ==========================================================
    // reset values
    localparam logic [7:0] STATUS_FLAGS_REG_RST = 8'h00;
    localparam logic [15:0] SP_RST = 16'hffff;
    localparam logic [7:0] PAGE_RST = 8'h00;

    // ==========================================================
    // instruction lengths in clock cycles
    localparam logic [1:0] CYC_ALU = 2'h1;
    localparam logic [1:0] CYC_MEM = 2'h2;
    localparam logic [1:0] CYC_XFETCH = 2'h3;

    // ==========================================================
    // commands, pointer modes and carriers
    typedef enum logic [4:0] {
        OP_NOP, OP_INDIRECT_LOAD, OP_INDIRECT_STORE, OP_ABSOLUTE_LOAD,
        OP_ABSOLUTE_STORE, OP_PUSH, OP_POP, OP_IO_BIT_FORCE_ONE,
        OP_IO_BIT_FORCE_ZERO, OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY,
        OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT,
        OP_NIBBLE_SWAP, OP_BIT_TO_TRANSFER_FLAG, OP_TRANSFER_FLAG_TO_BIT,
        OP_FLAG_ON, OP_FLAG_OFF, OP_EXTENDED_PROG_FETCH
    } lsb_op_t;
    typedef enum logic [1:0] {PM_PLAIN, PM_POST_INC, PM_PRE_DEC, PM_OFFSET} lsb_pmode_t;
    typedef enum logic [1:0] {PS_X, PS_Y, PS_Z, PS_ZALT} lsb_psel_t;
    typedef struct packed {
        lsb_pmode_t pmode;
        lsb_psel_t psel;
        logic [5:0] disp;
        logic [2:0] bitn;
        logic [4:0] rsel;
        lsb_op_t op;
    } lsb_cmd_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } lsb_dm_req_t;
    typedef struct packed {
        logic [5:0] addr;
        logic [2:0] bitn;
        logic set;
        logic clr;
    } lsb_io_req_t;
    typedef struct packed {
        logic [23:0] addr;
        logic re;
    } lsb_pm_req_t;

    // cycles an operation occupies the unit
    function automatic logic [1:0] lsb_ncyc(input lsb_op_t op);
        case (op)
            OP_INDIRECT_LOAD, OP_INDIRECT_STORE, OP_ABSOLUTE_LOAD, OP_ABSOLUTE_STORE,
            OP_PUSH, OP_POP, OP_IO_BIT_FORCE_ONE, OP_IO_BIT_FORCE_ZERO: lsb_ncyc = CYC_MEM;
            OP_EXTENDED_PROG_FETCH: lsb_ncyc = CYC_XFETCH;
            default: lsb_ncyc = CYC_ALU;
        endcase
    endfunction

endpackage

// ===== rtl/lsb_bit_alu.sv
// single-cycle shift, rotate, bit transfer and flag datapath
`timescale 1ns/100ps
module lsb_bit_alu (
    // operation
    input wire lsb_pkg::lsb_op_t op,
    input wire logic [2:0] bitn,
    // operands
    input wire logic [7:0] val,
    input wire logic [7:0] flags,
    // results
    output logic [7:0] res,
    output logic [7:0] flags_n
);
    import lsb_pkg::*;

    // result and flag update; untouched flags pass straight through
    always_comb begin
        logic shift;
        shift = 1'b1;
        res = val;
        flags_n = flags;
        case (op)
            OP_ROTATE_LEFT_VIA_CARRY: begin
                res = {val[6:0], flags[FLG_C]};
                flags_n[FLG_C] = val[7];
            end
            OP_ROTATE_RIGHT_VIA_CARRY: begin
                res = {flags[FLG_C], val[7:1]};
                flags_n[FLG_C] = val[0];
            end
            OP_ARITH_SHIFT_RIGHT: begin
                res = {val[7], val[7:1]};
                flags_n[FLG_C] = val[0];
            end
            OP_LOGIC_SHIFT_LEFT: begin
                res = {val[6:0], 1'b0};
                flags_n[FLG_C] = val[7];
            end
            OP_LOGIC_SHIFT_RIGHT: begin
                res = {1'b0, val[7:1]};
                flags_n[FLG_C] = val[0];
            end
            default: begin
                shift = 1'b0;
                case (op)
                    OP_NIBBLE_SWAP: res = {val[3:0], val[7:4]};
                    OP_BIT_TO_TRANSFER_FLAG: flags_n[FLG_T] = val[bitn];
                    OP_TRANSFER_FLAG_TO_BIT: res[bitn] = flags[FLG_T];
                    OP_FLAG_ON: flags_n[bitn] = 1'b1;
                    OP_FLAG_OFF: flags_n[bitn] = 1'b0;
                    default: res = val;
                endcase
            end
        endcase
        // shifts set zero, negative and overflow = negative xor carry
        if (shift) begin
            flags_n[FLG_Z] = (res == 8'h00);
            flags_n[FLG_N] = res[7];
            flags_n[FLG_V] = res[7] ^ flags_n[FLG_C];
        end
    end

endmodule

// ===== bench/lsb_mem_model.sv
// data memory, stack, io space and program memory facing the execution unit
`timescale 1ns/100ps
module lsb_mem_model (
    // clock
    input wire logic hclk,
    // requests and answers
    input wire lsb_pkg::lsb_dm_req_t dm_req,
    output logic [7:0] dm_rdata,
    input wire lsb_pkg::lsb_io_req_t io_req,
    input wire lsb_pkg::lsb_pm_req_t pm_req,
    output logic [7:0] pm_rdata
);
    import lsb_pkg::*;
    logic [7:0] mem [0:65535];
    logic [7:0] io [0:63];
    logic [7:0] last;
    // idle read lines show the inverse of the last byte so a stale value never matches
    assign dm_rdata = dm_req.re ? mem[dm_req.addr] : ~last;
    assign pm_rdata = pm_req.re ? pm_req.addr[7:0] ^ pm_req.addr[23:16] : ~last;
    // io space starts cleared so untouched bits can be checked
    initial begin
        last = 8'h00;
        foreach (io[k]) io[k] = 8'h00;
    end
    // writes and bit updates land at the end of the request cycle
    always @(posedge hclk) begin
        if (dm_req.re) last <= mem[dm_req.addr];
        if (dm_req.we) mem[dm_req.addr] <= dm_req.wdata;
        if (io_req.set) io[io_req.addr][io_req.bitn] <= 1'b1;
        if (io_req.clr) io[io_req.addr][io_req.bitn] <= 1'b0;
    end
endmodule

// ===== bench/testbench.sv
// random and corner tests of the execution unit over its register bus
`timescale 1ns/100ps
module testbench;
    import lsb_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, rnd;
    logic [7:0] dm_rdata, pm_rdata, v, f;
    logic [15:0] p, q;
    lsb_op_t o;
    lsb_dm_req_t dm_req;
    lsb_io_req_t io_req;
    lsb_pm_req_t pm_req;
    int err_total, n_checks, cyc;
    assign hready = hreadyout;
    lsb_exec_unit i_lsb_exec_unit (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dm_req(dm_req),
        .dm_rdata(dm_rdata), .io_req(io_req), .pm_req(pm_req), .pm_rdata(pm_rdata));
    lsb_mem_model i_lsb_mem_model (.hclk(hclk), .dm_req(dm_req), .dm_rdata(dm_rdata),
        .io_req(io_req), .pm_req(pm_req), .pm_rdata(pm_rdata));
    // clock and hang guard
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    // ==========================================================
    // helpers
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected {flags, result} of a shift; sign test is left alone
    function automatic logic [15:0] shf(input lsb_op_t op, input logic [7:0] x, fl);
        logic [7:0] r;
        logic c;
        case (op)
            OP_ROTATE_LEFT_VIA_CARRY: {c, r} = {x, fl[FLG_C]};
            OP_ROTATE_RIGHT_VIA_CARRY: {r, c} = {fl[FLG_C], x};
            default: {r, c} = {x[7], x};
        endcase
        fl[FLG_C] = c;
        fl[FLG_Z] = (r == 8'h00);
        fl[FLG_N] = r[7];
        fl[FLG_V] = r[7] ^ c;
        return {fl, r};
    endfunction
    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        n_checks++;
        if (s !== x) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    // one single transfer; answer taken at the edge that ends the data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic setr(input logic [4:0] r, input logic [7:0] d);
        bus(1'b1, OFF_GSEL, {27'h0, r});
        bus(1'b1, OFF_GDATA, {24'h0, d});
    endtask
    task automatic getr(input logic [4:0] r);
        bus(1'b1, OFF_GSEL, {27'h0, r});
        bus(1'b0, OFF_GDATA, 32'h0);
    endtask
    task automatic ptr(input logic [4:0] lo, input logic [15:0] d);
        setr(lo, d[7:0]);
        setr(lo + 5'h1, d[15:8]);
    endtask
    task automatic gp(input logic [4:0] lo);
        getr(lo + 5'h1);
        q[15:8] = rd[7:0];
        getr(lo);
        q[7:0] = rd[7:0];
    endtask
    // launch a command and poll busy
    task automatic run(lsb_op_t op, logic [4:0] r, logic [2:0] b, logic [5:0] d, lsb_psel_t ps,
        lsb_pmode_t pm);
        bus(1'b1, OFF_CMD, {9'h0, pm, ps, d, b, r, op});
        bus(1'b0, OFF_STAT, 32'h0);
        for (int k = 0; k < 8 && rd[STAT_BUSY_BIT] !== 1'b0; k++) bus(1'b0, OFF_STAT, 32'h0);
    endtask
    task automatic go(lsb_op_t x, logic [4:0] r, logic [2:0] b);
        run(x, r, b, 0, PS_X, PM_PLAIN);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence; first pointer 0x00ff carries into the high byte
    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata, f, err_total, n_checks, cyc} = '0;
        hsel = 1'b1;
        hsize = 3'h2;
        rnd = 32'd98862;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, OFF_SP, 32'h0);
        chk(rd[15:0], SP_RST);
        for (int i = 0; i < 12; i++) begin
            rnd = nx(rnd);
            {v, p} = (i == 0) ? {8'h5a, 16'h00ff} : rnd[23:0];
            setr(5, v);
            setr(7, ~v);
            ptr(PTR_X_LO, p);
            run(OP_INDIRECT_STORE, 5, 0, 0, PS_X, PM_POST_INC);
            chk(i_lsb_mem_model.mem[p], v);
            gp(PTR_X_LO);
            chk(q, p + 16'h1);
            run(OP_INDIRECT_LOAD, 6, 0, 0, PS_X, PM_PRE_DEC);
            getr(6);
            chk(rd[7:0], v);
            ptr(PTR_Z_LO, p + 16'h1);
            run(OP_INDIRECT_STORE, 7, 0, 0, PS_Z, PM_PRE_DEC);
            run(OP_INDIRECT_LOAD, 8, 0, 0, PS_Z, PM_POST_INC);
            getr(8);
            chk(rd[7:0], {~v});
            gp(PTR_Z_LO);
            chk(q, p + 16'h1);
            ptr(PTR_Y_LO, p - rnd[29:24]);
            run(OP_INDIRECT_LOAD, 9, 0, rnd[29:24], PS_Y, PM_OFFSET);
            getr(9);
            chk(rd[7:0], {~v});
            run(OP_INDIRECT_STORE, 5, 0, rnd[29:24], PS_Y, PM_OFFSET);
            chk(i_lsb_mem_model.mem[p], v);
        end
        // absolute and stack access
        bus(1'b1, OFF_ADDR, 32'h1234);
        go(OP_ABSOLUTE_STORE, 5, 0);
        go(OP_ABSOLUTE_LOAD, 10, 0);
        go(OP_PUSH, 7, 0);
        go(OP_POP, 11, 0);
        chk(i_lsb_mem_model.mem[16'h1234], v);
        chk(i_lsb_mem_model.mem[SP_RST], {~v});
        getr(10);
        chk(rd[7:0], v);
        getr(11);
        chk(rd[7:0], {~v});
        // flags, shifts and T moves
        for (int i = 0; i < 9; i++) begin
            rnd = nx(rnd);
            o = lsb_op_t'(OP_ROTATE_LEFT_VIA_CARRY + i % 3);
            setr(12, rnd[7:0]);
            go(lsb_op_t'(OP_FLAG_OFF - rnd[8]), 0, rnd[11:9]);
            f[rnd[11:9]] = rnd[8];
            {f, v} = shf(o, rnd[7:0], f);
            go(o, 12, 0);
            go(OP_BIT_TO_TRANSFER_FLAG, 12, rnd[14:12]);
            go(OP_TRANSFER_FLAG_TO_BIT, 12, rnd[17:15]);
            f[FLG_T] = v[rnd[14:12]];
            v[rnd[17:15]] = f[FLG_T];
            getr(12);
            chk(rd[7:0], v);
            bus(1'b0, OFF_STAT, 32'h0);
            chk(rd[7:0], f);
        end
        test_done();
    end
endmodule
